// ---- logic/cache_map.svh ----
/*
 constants for the coherent cache: widths, i/o space decode, reset values.
 assumes it is included by bare name from the package and the design modules.
*/
`ifndef CACHE_MAP_SVH
`define CACHE_MAP_SVH

// ----------------------------------------------------------------
// widths
// ----------------------------------------------------------------
`define ADDR_W 30
`define DATA_W 32
`define INDEX_W 8

// ----------------------------------------------------------------
// i/o space: word address is i/o when (addr & mask) == match
// ----------------------------------------------------------------
`define IO_MASK 30'h3000_0000
`define IO_MATCH 30'h3000_0000

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RST_DATA 32'h0000_0000

`endif

// ---- logic/cache_pkg.sv ----
/*
 types shared by the coherent cache and its surroundings.
 assumes cache_map.svh is on the include path.
*/
`include "cache_map.svh"

package cache_pkg;

   // ----------------------------------------------------------------
   // request carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic write;
      logic prefetch;
      logic mmu_fault;
      logic [`ADDR_W-1:0] addr;
      logic [`DATA_W-1:0] wdata;
   } cpu_req_t;

   typedef struct packed {
      logic write;
      logic [`ADDR_W-1:0] addr;
      logic [`DATA_W-1:0] wdata;
   } mem_req_t;

   // ----------------------------------------------------------------
   // controller states
   // ----------------------------------------------------------------
   typedef enum logic [0:0] {
      ST_IDLE = 1'b0,
      ST_MEM = 1'b1
   } cache_state_t;

endpackage

// ---- logic/io_space_decode.sv ----
/*
 physical address decode of the i/o region.
 assumes a word address of ADDR_W bits from the same clock domain.
*/
`include "cache_map.svh"

module io_space_decode #(
   parameter logic [`ADDR_W-1:0] IO_MASK = `IO_MASK,
   parameter logic [`ADDR_W-1:0] IO_MATCH = `IO_MATCH
) (
   // address in
   input wire logic [`ADDR_W-1:0] i_addr,
   // decode out
   output logic o_is_io
);

   wire logic [`ADDR_W-1:0] masked;

   assign masked = i_addr & IO_MASK;
   assign o_is_io = (masked == IO_MATCH);

endmodule

// ---- logic/coherent_cache.sv ----
/*
 direct-mapped write-through cache between cpu and shared memory bus,
 with bus snooping of external writes and uncached i/o space.
 assumes one clock, a bus that serialises all masters, and a snoop port
 that shows every write that another master completes on the bus.
*/
// Functional notes
// - cache visible only in timing and errors
// - dma reads see stores: write-through, nothing dirty
// - cpu reads after dma write see new data
// - write-through, snoop external writes, update entries
// - halt leaves no store held in cache
// - power-fail halt: memory already holds every store
// - i/o references never cached, go bus except a prefetch with mmu fault
// - prefetch mmu exception held until demand use, dropped for i/o
// - init leaves cache empty
// - recoverable cache error raises interrupt request
// - fatal error faults the access, also interrupt
// - error interrupt raised before context switch allowed
`include "cache_map.svh"

module coherent_cache #(
   parameter int INDEX_W = `INDEX_W
) (
   // clock and reset
   input wire logic i_clk_sys,
   input wire logic i_resetn,
   // cpu request and response
   input wire logic i_cpu_valid,
   input wire cache_pkg::cpu_req_t i_cpu_req,
   output logic o_cpu_ready,
   output logic o_cpu_rvalid,
   output logic [`DATA_W-1:0] o_cpu_rdata,
   output logic o_cpu_fault,
   // memory bus master
   output logic o_mem_valid,
   output cache_pkg::mem_req_t o_mem_req,
   input wire logic i_mem_ack,
   input wire logic i_mem_err,
   input wire logic [`DATA_W-1:0] i_mem_rdata,
   // bus snoop of other masters
   input wire logic i_snoop_valid,
   input wire cache_pkg::mem_req_t i_snoop,
   // processor control
   input wire logic i_init,
   input wire logic i_halt,
   output logic o_halt_done,
   input wire logic i_ctx_req,
   output logic o_ctx_ok,
   input wire logic i_err_clear,
   output logic o_err_irq
);

   localparam int LINES = 1 << INDEX_W;
   localparam int TAG_W = `ADDR_W - INDEX_W;

   // ----------------------------------------------------------------
   // storage
   // ----------------------------------------------------------------
   logic [TAG_W-1:0] tag_mem [LINES];
   logic [`DATA_W-1:0] data_mem [LINES];
   logic [LINES-1:0] valid;
   logic [LINES-1:0] par;
   logic [LINES-1:0] pf_fault;

   cache_pkg::cache_state_t state;
   cache_pkg::cache_state_t next_state;
   cache_pkg::cpu_req_t req;
   logic req_io;
   logic err_irq;
   logic rvalid;
   logic [`DATA_W-1:0] rdata;
   logic rfault;

   // ----------------------------------------------------------------
   // i/o decode ahead of lookup
   // ----------------------------------------------------------------
   wire logic a_io;

   io_space_decode u_io_decode (
      .i_addr(i_cpu_req.addr),
      .o_is_io(a_io)
   );

   // ----------------------------------------------------------------
   // lookup of the incoming request
   // ----------------------------------------------------------------
   wire logic accept;
   wire logic [INDEX_W-1:0] a_idx;
   wire logic [TAG_W-1:0] a_tag;
   wire logic a_hit;
   wire logic a_perr;
   wire logic a_read;
   wire logic pf_mmu;
   wire logic hit_resp;
   wire logic perr_miss;
   wire logic go_mem;

   assign accept = i_cpu_valid && (state == cache_pkg::ST_IDLE);
   assign a_idx = i_cpu_req.addr[INDEX_W-1:0];
   assign a_tag = i_cpu_req.addr[`ADDR_W-1:INDEX_W];
   // an i/o address never reaches the tag compare
   assign a_hit = !a_io && valid[a_idx] && (tag_mem[a_idx] == a_tag);
   assign a_perr = a_hit && ((^data_mem[a_idx]) != par[a_idx]);
   assign a_read = accept && !i_cpu_req.write;
   // translation failed on a prefetch: remember it, raise nothing yet
   assign pf_mmu = a_read && i_cpu_req.prefetch && i_cpu_req.mmu_fault;
   assign hit_resp = a_read && !pf_mmu && a_hit && !a_perr;
   // bad parity: drop the line and refetch so the access still completes
   assign perr_miss = a_read && !pf_mmu && a_perr;
   assign go_mem = accept && !pf_mmu && !hit_resp;

   // ----------------------------------------------------------------
   // memory side of the latched request
   // ----------------------------------------------------------------
   wire logic [INDEX_W-1:0] m_idx;
   wire logic [TAG_W-1:0] m_tag;
   wire logic m_hit;
   wire logic ack;
   wire logic fill;
   wire logic wupd;
   wire logic mem_fault;

   assign m_idx = req.addr[INDEX_W-1:0];
   assign m_tag = req.addr[`ADDR_W-1:INDEX_W];
   assign m_hit = !req_io && valid[m_idx] && (tag_mem[m_idx] == m_tag);
   assign ack = (state == cache_pkg::ST_MEM) && i_mem_ack;
   // uncached i/o data is passed on but never allocated
   assign fill = ack && !req.write && !req_io && !i_mem_err;
   // stores always go to memory; a hit is only refreshed
   assign wupd = ack && req.write && !i_mem_err && m_hit;
   // a prefetch that fails on the bus is not reported
   assign mem_fault = ack && i_mem_err && !req.prefetch;

   // ----------------------------------------------------------------
   // line write port: fill, store update or held prefetch fault
   // ----------------------------------------------------------------
   wire logic pf_line;
   wire logic wr_en;
   wire logic [INDEX_W-1:0] wr_idx;
   wire logic [TAG_W-1:0] wr_tag;
   wire logic [`DATA_W-1:0] wr_data;

   assign pf_line = pf_mmu && !a_io;
   assign wr_en = fill || wupd || pf_line;
   assign wr_idx = pf_line ? a_idx : m_idx;
   assign wr_tag = pf_line ? a_tag : m_tag;
   assign wr_data = pf_line ? `RST_DATA :
                    (fill ? i_mem_rdata : req.wdata);

   // ----------------------------------------------------------------
   // snoop of external writes
   // ----------------------------------------------------------------
   wire logic snoop_w;
   wire logic [INDEX_W-1:0] s_idx;
   wire logic [TAG_W-1:0] s_tag;
   wire logic snoop_hit;
   wire logic snoop_clash;
   wire logic same_wr, snoop_upd;

   assign snoop_w = i_snoop_valid && i_snoop.write;
   assign s_idx = i_snoop.addr[INDEX_W-1:0];
   assign s_tag = i_snoop.addr[`ADDR_W-1:INDEX_W];
   assign snoop_hit = snoop_w && valid[s_idx] && (tag_mem[s_idx] == s_tag);
   // a line rewritten this edge takes no snoop data; same tag drops it
   assign same_wr = wr_en && (s_idx == wr_idx);
   assign snoop_clash = snoop_w && same_wr && (s_tag == wr_tag);
   assign snoop_upd = snoop_hit && !same_wr;

   // ----------------------------------------------------------------
   // tag and data arrays carry no reset; valid bits gate them
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk_sys) begin
      if (wr_en) begin
         tag_mem[wr_idx] <= wr_tag;
         data_mem[wr_idx] <= wr_data;
      end
      if (snoop_upd) begin
         data_mem[s_idx] <= i_snoop.wdata;
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         valid <= '0;
         par <= '0;
         pf_fault <= '0;
      end else if (i_init) begin
         valid <= '0;
      end else begin
         if (perr_miss) begin
            valid[a_idx] <= 1'b0;
         end
         if (wr_en) begin
            valid[wr_idx] <= 1'b1;
            par[wr_idx] <= ^wr_data;
            pf_fault[wr_idx] <= pf_line;
         end
         if (snoop_clash) begin
            valid[s_idx] <= 1'b0;
         end else if (snoop_upd) begin
            par[s_idx] <= ^i_snoop.wdata;
         end
      end
   end

   // ----------------------------------------------------------------
   // controller
   // ----------------------------------------------------------------
   always_comb begin
      next_state = state;
      case (state)
         cache_pkg::ST_IDLE: begin
            if (go_mem) begin
               next_state = cache_pkg::ST_MEM;
            end
         end
         cache_pkg::ST_MEM: begin
            if (i_mem_ack) begin
               next_state = cache_pkg::ST_IDLE;
            end
         end
         default: begin
            next_state = cache_pkg::ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         state <= cache_pkg::ST_IDLE;
         req <= '0;
         req_io <= 1'b0;
      end else begin
         state <= next_state;
         if (go_mem) begin
            req <= i_cpu_req;
            req_io <= a_io;
         end
      end
   end

   // ----------------------------------------------------------------
   // response: only timing differs from an uncached system
   // ----------------------------------------------------------------
   wire logic next_rvalid;
   wire logic [`DATA_W-1:0] next_rdata;
   wire logic next_rfault;

   assign next_rvalid = hit_resp || pf_mmu || ack;
   assign next_rdata = hit_resp ? data_mem[a_idx] :
                       ((ack && !i_mem_err) ? i_mem_rdata : `RST_DATA);
   // a held prefetch fault surfaces on the first demand use
   assign next_rfault = hit_resp ?
                        (pf_fault[a_idx] && !i_cpu_req.prefetch) :
                        mem_fault;

   always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         rvalid <= 1'b0;
         rdata <= `RST_DATA;
         rfault <= 1'b0;
      end else begin
         rvalid <= next_rvalid;
         rdata <= next_rdata;
         rfault <= next_rfault;
      end
   end

   // ----------------------------------------------------------------
   // error interrupt request: a level, set beats clear
   // ----------------------------------------------------------------
   wire logic err_set;

   assign err_set = perr_miss || mem_fault;

   always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         err_irq <= 1'b0;
      end else begin
         err_irq <= err_set || (err_irq && !i_err_clear);
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign o_cpu_ready = (state == cache_pkg::ST_IDLE);
   assign o_cpu_rvalid = rvalid;
   assign o_cpu_rdata = rdata;
   assign o_cpu_fault = rfault;
   assign o_mem_valid = (state == cache_pkg::ST_MEM);
   assign o_mem_req.write = req.write;
   assign o_mem_req.addr = req.addr;
   assign o_mem_req.wdata = req.wdata;
   // idle means no store is outstanding anywhere in the cache
   assign o_halt_done = i_halt && (state == cache_pkg::ST_IDLE) && !rvalid;
   // no access in flight, so any error irq is already raised
   assign o_ctx_ok = i_ctx_req && (state == cache_pkg::ST_IDLE) && !rvalid;
   assign o_err_irq = err_irq;

endmodule

// ---- tb/coherent_cache_asserts.sv ----
/*
 port checker for coherent_cache, bound to every instance.
 assumes the i/o decode constants of cache_map.svh.
*/
`include "cache_map.svh"

module coherent_cache_asserts (
   // clock and reset
   input wire logic i_clk_sys,
   input wire logic i_resetn,
   // cpu
   input wire logic i_cpu_valid,
   input wire cache_pkg::cpu_req_t i_cpu_req,
   input wire logic o_cpu_ready,
   input wire logic o_cpu_rvalid,
   input wire logic o_cpu_fault,
   // bus
   input wire logic o_mem_valid,
   input wire cache_pkg::mem_req_t o_mem_req,
   input wire logic i_mem_ack,
   input wire logic i_mem_err,
   // control
   input wire logic o_ctx_ok,
   input wire logic i_err_clear,
   input wire logic o_err_irq
);
   logic take;
   logic io;
   logic bus_err;
   logic pf_q;
   logic err_seen;
   assign take = i_cpu_valid && o_cpu_ready;
   assign io = (i_cpu_req.addr & `IO_MASK) == `IO_MATCH;
   assign bus_err = o_mem_valid && i_mem_ack && i_mem_err;
   // prefetch bus errors stay silent, so the kind must be remembered
   always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn)
         pf_q <= 1'b0;
      else if (take)
         pf_q <= i_cpu_req.prefetch;
   end
   // demand bus errors not yet cleared: irq must be up before a switch
   always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn)
         err_seen <= 1'b0;
      else
         err_seen <= (bus_err && !pf_q) || (err_seen && !i_err_clear);
   end

   default clocking cb @(posedge i_clk_sys);
   endclocking
   default disable iff (!i_resetn);

   property p_io;
      take && io && !i_cpu_req.mmu_fault |=> o_mem_valid
         && o_mem_req.addr == $past(i_cpu_req.addr);
   endproperty
   a_io: assert property (p_io) else $error("io not on bus");
   property p_wr;
      take && i_cpu_req.write |=> o_mem_valid && o_mem_req.write
         && o_mem_req.wdata == $past(i_cpu_req.wdata);
   endproperty
   a_wr: assert property (p_wr) else $error("no write-through");
   property p_hold;
      o_mem_valid && !i_mem_ack |=> o_mem_valid && $stable(o_mem_req);
   endproperty
   a_hold: assert property (p_hold) else $error("bus request moved");
   property p_ack;
      o_mem_valid && i_mem_ack |=> o_cpu_rvalid && o_cpu_ready && !o_mem_valid;
   endproperty
   a_ack: assert property (p_ack) else $error("no answer after ack");
   property p_flt;
      bus_err && !pf_q |=> o_cpu_fault && o_err_irq;
   endproperty
   a_flt: assert property (p_flt) else $error("bus error not faulted");
   property p_pfm;
      take && i_cpu_req.prefetch && i_cpu_req.mmu_fault && !io
         |=> o_cpu_rvalid && !o_cpu_fault && !o_mem_valid;
   endproperty
   a_pfm: assert property (p_pfm) else $error("prefetch fault early");
   property p_ctx;
      o_ctx_ok |-> !o_mem_valid && o_cpu_ready && (o_err_irq || !err_seen);
   endproperty
   a_ctx: assert property (p_ctx) else $error("switch while busy");
   property p_irq;
      o_err_irq && !i_err_clear |=> o_err_irq;
   endproperty
   a_irq: assert property (p_irq) else $error("irq dropped");

   c_io: cover property (take && io);
   c_err: cover property (bus_err);
   c_ctx: cover property (o_ctx_ok && o_err_irq);
endmodule

bind coherent_cache coherent_cache_asserts u_chk (
   .i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_cpu_valid(i_cpu_valid),
   .i_cpu_req(i_cpu_req), .o_cpu_ready(o_cpu_ready),
   .o_cpu_rvalid(o_cpu_rvalid), .o_cpu_fault(o_cpu_fault),
   .o_mem_valid(o_mem_valid), .o_mem_req(o_mem_req), .i_mem_ack(i_mem_ack),
   .i_mem_err(i_mem_err), .o_ctx_ok(o_ctx_ok), .i_err_clear(i_err_clear),
   .o_err_irq(o_err_irq));

// ---- tb/mem_bus_model.sv ----
/*
 shared memory behind the cache's bus port; also takes dma writes.
 assumes one clock; latency per access comes from i_lat.
*/
`include "cache_map.svh"

module mem_bus_model #(
   parameter logic [`ADDR_W-1:0] ERR_ADDR = 30'h0000_000c
) (
   // clock and reset
   input wire logic i_clk_sys,
   input wire logic i_resetn,
   // bus
   input wire logic [3:0] i_lat,
   input wire logic i_mem_valid,
   input wire cache_pkg::mem_req_t i_mem_req,
   output logic o_mem_ack,
   output logic o_mem_err,
   output logic [`DATA_W-1:0] o_mem_rdata,
   // other master
   input wire logic i_dma_valid,
   input wire cache_pkg::mem_req_t i_dma
);
   logic [`DATA_W-1:0] mem [16];
   logic [3:0] cnt;
   logic [3:0] idx;
   logic bad;
   assign idx = i_mem_req.addr[3:0];
   assign bad = i_mem_req.addr == ERR_ADDR;
   initial for (int i = 0; i < 16; i++) mem[i] = 32'h5a00_0000 + i;
   always @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         cnt <= 4'h0;
         o_mem_ack <= 1'b0;
         o_mem_err <= 1'b0;
         o_mem_rdata <= 32'hffff_ffff;
      end else begin
         o_mem_ack <= 1'b0;
         o_mem_err <= 1'b0;
         // outside an answer the data lines wander
         o_mem_rdata <= ~o_mem_rdata;
         if (i_mem_valid && !o_mem_ack) begin
            cnt <= cnt + 4'h1;
            if (cnt == i_lat) begin
               cnt <= 4'h0;
               o_mem_ack <= 1'b1;
               o_mem_err <= bad;
               o_mem_rdata <= mem[idx];
               if (i_mem_req.write && !bad)
                  mem[idx] <= i_mem_req.wdata;
            end
         end
         if (i_dma_valid && i_dma.write)
            mem[i_dma.addr[3:0]] <= i_dma.wdata;
      end
   end
endmodule

// ---- tb/tb_coherent_cache.sv ----
/*
 bench for coherent_cache: a table of cpu accesses, then dma, halt,
 bus error, context switch and init cases.
 assumes the package, the checker and the bus model are compiled first.
*/
module tb_coherent_cache;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct packed {
      logic w;
      logic pf;
      logic mf;
      logic [29:0] a;
      logic [31:0] d;
      logic [31:0] exp;
      logic f;
      int nb;
   } row_t;
   localparam logic [29:0] ad_a = 30'h0000_0004;
   localparam logic [29:0] ad_b = 30'h0000_0008;
   localparam logic [29:0] ad_io = 30'h3000_0005;
   localparam logic [29:0] ad_pf = 30'h0000_0001;
   localparam logic [29:0] ad_err = 30'h0000_000c;
   logic i_clk_sys = 1'b0;
   logic i_resetn = 1'b0;
   logic i_cpu_valid = 1'b0;
   cache_pkg::cpu_req_t i_cpu_req = '0;
   logic i_snoop_valid = 1'b0;
   cache_pkg::mem_req_t i_snoop = '0;
   logic i_init = 1'b0;
   logic i_halt = 1'b0;
   logic i_ctx_req = 1'b0;
   logic i_err_clear = 1'b0;
   logic [3:0] lat = 4'h0;
   logic o_cpu_ready, o_cpu_rvalid, o_cpu_fault, o_mem_valid, i_mem_ack;
   logic i_mem_err, o_halt_done, o_ctx_ok, o_err_irq, got_f;
   logic [31:0] o_cpu_rdata, i_mem_rdata, got_d;
   cache_pkg::mem_req_t o_mem_req;
   int err_count = 0;
   int n_compared = 0;
   int n_bus = 0;
   int cycles = 0;
   int got_nb;
   row_t rows [10];

   coherent_cache #(.INDEX_W(2)) dut (
      .i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_cpu_valid(i_cpu_valid),
      .i_cpu_req(i_cpu_req), .o_cpu_ready(o_cpu_ready),
      .o_cpu_rvalid(o_cpu_rvalid), .o_cpu_rdata(o_cpu_rdata),
      .o_cpu_fault(o_cpu_fault), .o_mem_valid(o_mem_valid),
      .o_mem_req(o_mem_req), .i_mem_ack(i_mem_ack), .i_mem_err(i_mem_err),
      .i_mem_rdata(i_mem_rdata), .i_snoop_valid(i_snoop_valid),
      .i_snoop(i_snoop), .i_init(i_init), .i_halt(i_halt),
      .o_halt_done(o_halt_done), .i_ctx_req(i_ctx_req), .o_ctx_ok(o_ctx_ok),
      .i_err_clear(i_err_clear), .o_err_irq(o_err_irq));
   mem_bus_model m (
      .i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_lat(lat),
      .i_mem_valid(o_mem_valid), .i_mem_req(o_mem_req), .o_mem_ack(i_mem_ack),
      .o_mem_err(i_mem_err), .o_mem_rdata(i_mem_rdata),
      .i_dma_valid(i_snoop_valid), .i_dma(i_snoop));

   always #10 i_clk_sys = ~i_clk_sys;
   always @(posedge i_clk_sys) begin
      n_bus += int'(o_mem_valid && i_mem_ack);
      cycles++;
      if (cycles == 5000) begin
         err_count++;
         results();
      end
   end

   task results;
      if (err_count == 0 && n_compared > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task chk(input logic ok, input string msg);
      n_compared++;
      if (ok !== 1'b1) begin
         err_count++;
         $display("ERROR %0t %s", $time, msg);
      end
   endtask
   task op(input logic w, pf, mf, input logic [29:0] a, input logic [31:0] d);
      int n0;
      int k;
      n0 = n_bus;
      @(negedge i_clk_sys);
      i_cpu_valid = 1'b1;
      i_cpu_req = {w, pf, mf, a, d};
      @(negedge i_clk_sys);
      i_cpu_valid = 1'b0;
      for (k = 0; k < 40 && o_cpu_rvalid !== 1'b1; k++) @(negedge i_clk_sys);
      chk(k < 40, "no response");
      got_d = o_cpu_rdata;
      got_f = o_cpu_fault;
      got_nb = n_bus - n0;
   endtask

   initial begin
      // a write answers with the word that memory held before it
      rows = '{'{1, 0, 0, ad_a, 32'h1111_2222, 32'h5a00_0004, 0, 1},
         '{0, 0, 0, ad_a, '0, 32'h1111_2222, 0, 1},
         '{0, 0, 0, ad_a, '0, 32'h1111_2222, 0, 0},
         '{0, 0, 0, ad_b, '0, 32'h5a00_0008, 0, 1},
         '{1, 0, 0, ad_b, 32'h3333_4444, 32'h5a00_0008, 0, 1},
         '{0, 0, 0, ad_b, '0, 32'h3333_4444, 0, 0},
         '{1, 0, 0, ad_io, 32'h7777_8888, 32'h5a00_0005, 0, 1},
         '{0, 0, 0, ad_io, '0, 32'h7777_8888, 0, 1},
         '{0, 1, 1, ad_pf, '0, '0, 0, 0},
         '{0, 0, 0, ad_pf, '0, '0, 1, 0}};
      repeat (6) @(posedge i_clk_sys);
      @(negedge i_clk_sys);
      i_resetn = 1'b1;
      chk(o_cpu_ready === 1'b1 && o_err_irq === 1'b0, "reset state");
      for (int i = 0; i < 10; i++) begin
         lat = (i % 2) ? 4'h3 : 4'h0;
         op(rows[i].w, rows[i].pf, rows[i].mf, rows[i].a, rows[i].d);
         chk(got_d === rows[i].exp && got_f === rows[i].f, "data");
         chk(got_nb == rows[i].nb, "bus use");
      end
      @(negedge i_clk_sys);
      i_snoop_valid = 1'b1;
      i_snoop = {1'b1, ad_b, 32'h9999_0000};
      @(negedge i_clk_sys);
      i_snoop_valid = 1'b0;
      op(0, 0, 0, ad_b, '0);
      chk(got_d === 32'h9999_0000 && got_nb == 0, "stale data");
      op(1, 0, 0, ad_a, 32'h2468_0000);
      i_halt = 1'b1;
      @(negedge i_clk_sys);
      chk(o_halt_done && m.mem[4] === 32'h2468_0000, "held");
      i_halt = 1'b0;
      lat = 4'h2;
      op(0, 0, 0, ad_err, '0);
      chk(got_f === 1'b1 && o_err_irq === 1'b1, "bus error");
      i_ctx_req = 1'b1;
      @(negedge i_clk_sys);
      chk(o_ctx_ok === 1'b1 && o_err_irq === 1'b1, "switch");
      i_ctx_req = 1'b0;
      i_err_clear = 1'b1;
      @(negedge i_clk_sys);
      i_err_clear = 1'b0;
      chk(o_err_irq === 1'b0, "irq stuck");
      op(0, 1, 0, ad_err, '0);
      chk(got_f === 1'b0 && o_err_irq === 1'b0, "prefetch error");
      i_init = 1'b1;
      @(negedge i_clk_sys);
      i_init = 1'b0;
      op(0, 0, 0, ad_b, '0);
      chk(got_nb == 1 && got_d === 32'h9999_0000, "init");
      op(0, 0, 0, ad_err, '0);
      chk(got_f === 1'b1 && o_err_irq === 1'b1, "error again");
      i_resetn = 1'b0;
      @(negedge i_clk_sys);
      chk(!o_err_irq && !o_mem_valid && o_cpu_ready, "mid reset");
      repeat (2) @(negedge i_clk_sys);
      i_resetn = 1'b1;
      op(0, 0, 0, ad_b, '0);
      chk(got_nb == 1 && got_d === 32'h9999_0000, "reset kept");
      results();
   end
endmodule
